//--- common/lrs_pkg.sv
`default_nettype none
package lrs_pkg;

   // ************************************************
   // geometry and register map
   // ************************************************
   localparam int         LRS_LANES     = 2;
   localparam int         LRS_AW        = 8;
   localparam int         LRS_DW        = 32;
   localparam logic [7:0] LRS_ADDR_CFG  = 8'h00;
   localparam logic [7:0] LRS_ADDR_STAT = 8'h04;
   localparam int         LRS_CFG_W     = 17;
   localparam int         LRS_STAT_OK   = 0;
   localparam int         LRS_STAT_INC  = 8;

   // ************************************************
   // event selects and unit masks
   // ************************************************
   localparam logic [7:0] LRS_EV_REQ    = 8'h24;
   localparam logic [7:0] LRS_EV_DATA   = 8'h26;
   localparam logic [7:0] LRS_EV_WRITE  = 8'h27;
   localparam logic [7:0] LRS_EV_WB     = 8'h28;
   localparam logic [7:0] LRS_VM_FULL   = 8'hff;
   localparam logic [7:0] LRS_VM_WB     = 8'h0f;
   localparam logic [7:0] LRS_UM_OWN    = 8'h0c;
   localparam logic [7:0] LRS_UM_CHIT   = 8'h10;
   localparam logic [7:0] LRS_UM_CMISS  = 8'h20;
   localparam logic [7:0] LRS_UM_CALL   = 8'h30;
   localparam logic [7:0] LRS_UM_PHIT   = 8'h40;
   localparam logic [7:0] LRS_UM_PMISS  = 8'h80;
   localparam logic [7:0] LRS_UM_PALL   = 8'hc0;
   localparam logic [7:0] LRS_UM_MISS   = 8'haa;
   localparam logic [7:0] LRS_UM_LO_ALL = 8'h0f;
   localparam logic [7:0] LRS_UM_HI_ALL = 8'hf0;
   localparam logic [7:0] LRS_UM_OHIT   = 8'h0e;
   localparam logic [7:0] LRS_UM_LHIT   = 8'he0;

   // ************************************************
   // request carrier from the cache pipeline
   // ************************************************
   typedef enum logic [3:0] {
      LRS_K_CODE_DEM  = 4'h0,
      LRS_K_CODE_L1PF = 4'h1,
      LRS_K_DATA_DEM  = 4'h2,
      LRS_K_DATA_L1PF = 4'h3,
      LRS_K_PF_CODE   = 4'h4,
      LRS_K_PF_DATA   = 4'h5,
      LRS_K_PF_OWN    = 4'h6,
      LRS_K_STORE_OWN = 4'h7,
      LRS_K_LOCK_OWN  = 4'h8,
      LRS_K_WRITEBACK = 4'h9
   } lrs_kind_t;

   typedef enum logic [1:0] {
      LRS_LINE_I = 2'h0,
      LRS_LINE_S = 2'h1,
      LRS_LINE_E = 2'h2,
      LRS_LINE_M = 2'h3
   } lrs_line_t;

   typedef struct packed {
      logic      vld;
      lrs_kind_t kind;
      lrs_line_t line;
   } lrs_req_t;

   typedef struct packed {
      logic       en;
      logic [7:0] umask;
      logic [7:0] evsel;
   } lrs_cfg_t;

   localparam lrs_cfg_t LRS_CFG_RST = '{en: 1'b0, umask: 8'h00, evsel: 8'h00};

endpackage
`default_nettype wire

//--- src/lrs_selector.sv
// Operation
// - select 24H mask 10H counts code fetches hitting second level.
// - select 24H mask 20H counts code fetches missing second level.
// - select 24H mask 30H counts all code fetches.
// - code fetches include first-level code demand misses and code prefetches.
// - select 24H mask 40H counts prefetch hits, code and data.
// - select 24H mask 80H counts prefetch misses, code and data.
// - select 24H mask C0H counts all prefetches.
// - select 24H mask AAH counts every miss except lock ownership and writebacks.
// - select 24H mask FFH counts every request except lock ownership and writebacks.
// - select 24H mask 0CH counts store and prefetch ownership requests, not lock ownership.
// - select 26H masks 01H-08H count demand loads per line state.
// - demand loads include first-level data misses and data prefetches.
// - select 26H masks 10H-80H count prefetch data loads per state.
// - ownership prefetch on Shared line is a miss, prefetch read a hit.
// - select 26H mask F0H counts all prefetch data requests.
// - select 26H mask FFH counts every data request.
// - select 27H masks 01H-08H count store ownership per state.
// - select 27H store hit mask counts S, E, M; all-states counts all.
// - ownership prefetches never count under select 27H.
// - select 27H masks 10H-80H count lock ownership per state.
// - select 27H lock hit mask counts S, E, M; F0H counts all.
// - select 28H masks 01H-08H count writebacks per line state.
`timescale 1ns/1ps
`default_nettype none
module lrs_selector
   import lrs_pkg::*;
(
   // clock and reset
   input  wire logic                     CLK,
   input  wire logic                     ARST_N,
   // register port
   input  wire logic [LRS_AW-1:0]        ADDR,
   input  wire logic [LRS_DW-1:0]        WDATA,
   input  wire logic                     WR,
   input  wire logic                     RD,
   output var  logic [LRS_DW-1:0]        RDATA,
   // cache pipeline requests
   input  wire lrs_req_t [LRS_LANES-1:0] REQ,
   // counter side
   output var  logic [1:0]               COUNT_INC,
   output var  logic                     COUNT_PULSE
);

   // ************************************************
   // decode helpers
   // ************************************************
   function automatic logic line_hit(lrs_req_t r);
      line_hit = (r.line != LRS_LINE_I) &&
                 !(r.kind == LRS_K_PF_OWN && r.line == LRS_LINE_S);
   endfunction

   function automatic logic mask_ok(lrs_cfg_t c);
      logic [7:0] vm;
      vm = 8'h00;
      if (c.evsel == LRS_EV_REQ || c.evsel == LRS_EV_DATA) begin
         vm = LRS_VM_FULL;
      end else if (c.evsel == LRS_EV_WRITE) begin
         vm = LRS_VM_FULL;
      end else if (c.evsel == LRS_EV_WB) begin
         vm = LRS_VM_WB;
      end
      mask_ok = (c.umask != 8'h00) && ((c.umask & ~vm) == 8'h00);
   endfunction

   function automatic logic lane_match(lrs_cfg_t c, lrs_req_t r);
      logic       hit;
      logic       ld;
      logic       own;
      logic       code;
      logic       pf;
      logic       pfd;
      logic [3:0] st;
      logic [7:0] sub;
      hit  = line_hit(r);
      ld   = r.kind == LRS_K_DATA_DEM || r.kind == LRS_K_DATA_L1PF;
      own  = r.kind == LRS_K_STORE_OWN || r.kind == LRS_K_PF_OWN;
      code = r.kind == LRS_K_CODE_DEM || r.kind == LRS_K_CODE_L1PF;
      pfd  = r.kind == LRS_K_PF_DATA || r.kind == LRS_K_PF_OWN;
      pf   = pfd || r.kind == LRS_K_PF_CODE;
      st   = 4'h1 << r.line;
      sub  = 8'h00;
      case (c.evsel)
         LRS_EV_REQ: begin
            sub[0] = ld & hit;
            sub[1] = ld & ~hit;
            sub[2] = own & hit;
            sub[3] = own & ~hit;
            sub[4] = code & hit;
            sub[5] = code & ~hit;
            sub[6] = pf & hit;
            sub[7] = pf & ~hit;
         end
         LRS_EV_DATA: begin
            sub[3:0] = ld ? st : 4'h0;
            sub[7:4] = pfd ? st : 4'h0;
         end
         LRS_EV_WRITE: begin
            sub[3:0] = (r.kind == LRS_K_STORE_OWN) ? st : 4'h0;
            sub[7:4] = (r.kind == LRS_K_LOCK_OWN) ? st : 4'h0;
         end
         LRS_EV_WB: begin
            sub[3:0] = (r.kind == LRS_K_WRITEBACK) ? st : 4'h0;
         end
         default: begin
            sub = 8'h00;
         end
      endcase
      lane_match = r.vld && c.en && mask_ok(c) && |(sub & c.umask);
   endfunction

   // ************************************************
   // configuration register
   // ************************************************
   lrs_cfg_t cfg_reg;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cfg_reg <= LRS_CFG_RST;
      end else if (WR && ADDR == LRS_ADDR_CFG) begin
         cfg_reg <= lrs_cfg_t'(WDATA[LRS_CFG_W-1:0]);
      end
   end

   // ************************************************
   // per-lane match and increment
   // ************************************************
   logic [LRS_LANES-1:0] match;
   logic [1:0]           inc_next;
   logic [1:0]           inc_reg;
   logic                 pulse_reg;

   genvar g;
   generate
      for (g = 0; g < LRS_LANES; g++) begin : g_lane
         assign match[g] = lane_match(cfg_reg, REQ[g]);
      end
   endgenerate

   always_comb begin
      inc_next = 2'h0;
      for (int i = 0; i < LRS_LANES; i++) begin
         inc_next = inc_next + {1'b0, match[i]};
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         inc_reg   <= 2'h0;
         pulse_reg <= 1'b0;
      end else begin
         inc_reg   <= inc_next;
         pulse_reg <= |match;
      end
   end

   assign COUNT_INC   = inc_reg;
   assign COUNT_PULSE = pulse_reg;

   // ************************************************
   // register read
   // ************************************************
   logic [LRS_DW-1:0] rdata_reg;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_reg <= '0;
      end else if (RD) begin
         if (ADDR == LRS_ADDR_CFG) begin
            rdata_reg <= {{(LRS_DW-LRS_CFG_W){1'b0}}, cfg_reg};
         end else if (ADDR == LRS_ADDR_STAT) begin
            rdata_reg <= '0;
            rdata_reg[LRS_STAT_OK] <= mask_ok(cfg_reg);
            rdata_reg[LRS_STAT_INC +: 2] <= inc_reg;
         end else begin
            rdata_reg <= '0;
         end
      end else begin
         rdata_reg <= '0;
      end
   end

   assign RDATA = rdata_reg;

   // ************************************************
   // checks
   // ************************************************
   lrs_req_t r0;
   lrs_req_t r1;
   logic     hit0;
   logic     quiet1;
   logic     on;
   logic [7:0] ev;
   logic [7:0] um;

   assign r0     = REQ[0];
   assign r1     = REQ[1];
   assign hit0   = r0.line != LRS_LINE_I;
   assign quiet1 = !r1.vld;
   assign on     = cfg_reg.en;
   assign ev     = cfg_reg.evsel;
   assign um     = cfg_reg.umask;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   a_code_hit_cnt: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_CHIT && quiet1 && r0.vld &&
      r0.kind == LRS_K_CODE_DEM && hit0 |=> COUNT_INC == 2'h1)
      else $error("code hit not counted");

   a_code_miss_cnt: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_CMISS && quiet1 && r0.vld &&
      r0.kind == LRS_K_CODE_L1PF |=> COUNT_INC == {1'b0, !hit0})
      else $error("code miss count wrong");

   a_code_all_cnt: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_CALL && r0.vld && r1.vld &&
      r0.kind == LRS_K_CODE_DEM && r1.kind == LRS_K_CODE_L1PF
      |=> COUNT_INC == 2'h2 && COUNT_PULSE)
      else $error("code fetches not both counted");

   a_pf_own_shared: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_PHIT && quiet1 && r0.vld &&
      r0.kind == LRS_K_PF_OWN && r0.line == LRS_LINE_S |=> COUNT_INC == 2'h0)
      else $error("shared ownership prefetch seen as hit");

   a_pf_all_cnt: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_PALL && quiet1 && r0.vld &&
      r0.kind == LRS_K_PF_CODE |=> COUNT_INC == 2'h1)
      else $error("prefetch not counted");

   a_miss_cnt: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_MISS && quiet1 && r0.vld &&
      r0.kind != LRS_K_LOCK_OWN && r0.kind != LRS_K_WRITEBACK
      |=> COUNT_INC == {1'b0, !$past(line_hit(r0))})
      else $error("miss count wrong");

   a_all_req_cnt: assert property (
      on && ev == LRS_EV_REQ && um == LRS_VM_FULL && quiet1 && r0.vld &&
      r0.kind == LRS_K_DATA_DEM |=> COUNT_PULSE)
      else $error("data request not counted");

   a_own_all_cnt: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_OWN && quiet1 && r0.vld &&
      r0.kind == LRS_K_PF_OWN |=> COUNT_INC == 2'h1)
      else $error("ownership prefetch not counted");

   a_demand_state: assert property (
      on && ev == LRS_EV_DATA && um == LRS_UM_LO_ALL && quiet1 && r0.vld &&
      r0.kind == LRS_K_DATA_L1PF |=> COUNT_INC == 2'h1)
      else $error("demand load not counted");

   a_pf_data_all: assert property (
      on && ev == LRS_EV_DATA && um == LRS_UM_HI_ALL && quiet1 && r0.vld &&
      r0.kind == LRS_K_DATA_DEM |=> COUNT_INC == 2'h0)
      else $error("demand load counted as prefetch");

   a_store_no_pf: assert property (
      on && ev == LRS_EV_WRITE && um == LRS_UM_LO_ALL && quiet1 && r0.vld &&
      r0.kind == LRS_K_PF_OWN |=> !COUNT_PULSE)
      else $error("ownership prefetch counted as store");

   a_store_hit: assert property (
      on && ev == LRS_EV_WRITE && um == LRS_UM_OHIT && quiet1 && r0.vld &&
      r0.kind == LRS_K_STORE_OWN |=> COUNT_INC == {1'b0, $past(hit0)})
      else $error("store ownership hit wrong");

   a_lock_hit: assert property (
      on && ev == LRS_EV_WRITE && um == LRS_UM_LHIT && quiet1 && r0.vld &&
      r0.kind == LRS_K_LOCK_OWN |=> COUNT_INC == {1'b0, $past(hit0)})
      else $error("lock ownership hit wrong");

   a_wb_state: assert property (
      on && ev == LRS_EV_WB && um == LRS_UM_LO_ALL && quiet1 && r0.vld &&
      r0.kind == LRS_K_WRITEBACK |=> COUNT_INC == 2'h1)
      else $error("writeback not counted");

   a_pf_hit_cnt: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_PHIT && quiet1 && r0.vld &&
      r0.kind == LRS_K_PF_DATA && r0.line == LRS_LINE_E |=> COUNT_INC == 2'h1)
      else $error("prefetch hit not counted");

   a_pf_miss_cnt: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_PMISS && quiet1 && r0.vld &&
      r0.kind == LRS_K_PF_CODE && r0.line == LRS_LINE_I |=> COUNT_INC == 2'h1)
      else $error("prefetch miss not counted");

   a_code_pf_hit: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_CHIT && quiet1 && r0.vld &&
      r0.kind == LRS_K_CODE_L1PF && r0.line == LRS_LINE_M |=> COUNT_INC == 2'h1)
      else $error("code prefetch hit not counted");

   a_code_not_data: assert property (
      on && ev == LRS_EV_REQ && um == LRS_UM_CHIT && quiet1 && r0.vld &&
      r0.kind == LRS_K_DATA_DEM |=> COUNT_INC == 2'h0)
      else $error("data load counted as code fetch");

   a_load_pf_cnt: assert property (
      on && ev == LRS_EV_DATA && um == 8'h02 && quiet1 && r0.vld &&
      r0.kind == LRS_K_DATA_L1PF && r0.line == LRS_LINE_S |=> COUNT_INC == 2'h1)
      else $error("data prefetch load not counted");

   a_pf_data_state: assert property (
      on && ev == LRS_EV_DATA && um == 8'h20 && quiet1 && r0.vld &&
      r0.kind == LRS_K_PF_OWN && r0.line == LRS_LINE_S |=> COUNT_INC == 2'h1)
      else $error("prefetch data state not counted");

   a_pf_data_cnt: assert property (
      on && ev == LRS_EV_DATA && um == LRS_UM_HI_ALL && quiet1 && r0.vld &&
      r0.kind == LRS_K_PF_DATA |=> COUNT_INC == 2'h1)
      else $error("prefetch data not counted");

   a_data_any: assert property (
      on && ev == LRS_EV_DATA && um == LRS_VM_FULL && quiet1 && r0.vld &&
      r0.kind == LRS_K_DATA_DEM |=> COUNT_INC == 2'h1)
      else $error("data request not counted");

   a_store_state: assert property (
      on && ev == LRS_EV_WRITE && um == 8'h08 && quiet1 && r0.vld &&
      r0.kind == LRS_K_STORE_OWN && r0.line == LRS_LINE_M |=> COUNT_INC == 2'h1)
      else $error("modified store ownership not counted");

   a_store_all: assert property (
      on && ev == LRS_EV_WRITE && um == LRS_UM_LO_ALL && quiet1 && r0.vld &&
      r0.kind == LRS_K_STORE_OWN |=> COUNT_INC == 2'h1)
      else $error("store ownership not counted");

   a_lock_state: assert property (
      on && ev == LRS_EV_WRITE && um == 8'h10 && quiet1 && r0.vld &&
      r0.kind == LRS_K_LOCK_OWN && r0.line == LRS_LINE_I |=> COUNT_INC == 2'h1)
      else $error("invalid lock ownership not counted");

   a_lock_all: assert property (
      on && ev == LRS_EV_WRITE && um == LRS_UM_HI_ALL && quiet1 && r0.vld &&
      r0.kind == LRS_K_LOCK_OWN |=> COUNT_INC == 2'h1)
      else $error("lock ownership not counted");

   a_wb_one_state: assert property (
      on && ev == LRS_EV_WB && um == 8'h04 && quiet1 && r0.vld &&
      r0.kind == LRS_K_WRITEBACK && r0.line == LRS_LINE_E |=> COUNT_INC == 2'h1)
      else $error("exclusive writeback not counted");

   a_wb_high_quiet: assert property (
      on && ev == LRS_EV_WB && um == LRS_UM_HI_ALL |=> COUNT_INC == 2'h0)
      else $error("writeback counted under undefined mask");

   a_two_lanes: assert property (
      on && ev == LRS_EV_WB && um == LRS_UM_LO_ALL && r0.vld && r1.vld &&
      r0.kind == LRS_K_WRITEBACK && r1.kind == LRS_K_WRITEBACK |=> COUNT_INC == 2'h2)
      else $error("two lanes not summed");

   a_undef_quiet: assert property (
      !mask_ok(cfg_reg) || !on |=> COUNT_INC == 2'h0 && !COUNT_PULSE)
      else $error("count under undefined selection");

   a_pulse_tracks: assert property (
      COUNT_PULSE == (COUNT_INC != 2'h0))
      else $error("pulse and increment disagree");

endmodule // lrs_selector
`default_nettype wire

//--- sim/lrs_cache_model.sv
`timescale 1ns/1ps
`default_nettype none
module lrs_cache_model
   import lrs_pkg::*;
(
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   // requests wanted by the bench
   input  wire lrs_req_t [LRS_LANES-1:0] cmd_req,
   // lanes toward the selector
   output var  lrs_req_t [LRS_LANES-1:0] req_out
);
   logic [5:0] pat_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pat_reg <= 6'h00;
      end else begin
         pat_reg <= pat_reg + 6'h01;
      end
   end

   // idle lanes carry a changing pattern, never a held value
   always_comb begin
      for (int i = 0; i < LRS_LANES; i++) begin
         req_out[i] = cmd_req[i].vld ? cmd_req[i] :
            '{vld: 1'b0, kind: lrs_kind_t'(pat_reg[3:0] ^ 4'(i)), line: lrs_line_t'(pat_reg[5:4])};
      end
   end
endmodule // lrs_cache_model
`default_nettype wire

//--- sim/lrs_selector_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lrs_selector_tb_top
   import lrs_pkg::*;
;
   logic                     clk;
   logic                     arst_n;
   logic [LRS_AW-1:0]        addr;
   logic [LRS_DW-1:0]        wdata;
   logic [LRS_DW-1:0]        rdata;
   logic                     wr;
   logic                     rd;
   lrs_req_t [LRS_LANES-1:0] cmd;
   lrs_req_t [LRS_LANES-1:0] req;
   logic [1:0]               cnt_inc;
   logic                     cnt_pulse;
   logic [31:0]              rd_val;
   logic [7:0]               sel_tab [4];
   int                       n_mismatch;
   int                       samples_checked;

   lrs_selector dut_u (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .REQ(req), .COUNT_INC(cnt_inc), .COUNT_PULSE(cnt_pulse));
   lrs_cache_model mdl_u (.clk(clk), .arst_n(arst_n), .cmd_req(cmd), .req_out(req));

   // ************************************************
   // clock, shared tasks
   // ************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   // expected match of one lane
   function automatic logic lane_hit(input logic [7:0] ev, input logic [7:0] um, input lrs_req_t r);
      logic       hit;
      logic [1:0] st;
      hit = (r.line != LRS_LINE_I) && !(r.kind == LRS_K_PF_OWN && r.line == LRS_LINE_S);
      st = r.line;
      lane_hit = 1'b0;
      if (r.vld && um != 8'h00) begin
         case (ev)
            8'h24: lane_hit = ((r.kind inside {LRS_K_CODE_DEM, LRS_K_CODE_L1PF}) && um[hit ? 4 : 5])
               || ((r.kind inside {LRS_K_DATA_DEM, LRS_K_DATA_L1PF}) && um[hit ? 0 : 1])
               || ((r.kind inside {LRS_K_STORE_OWN, LRS_K_PF_OWN}) && um[hit ? 2 : 3])
               || ((r.kind inside {LRS_K_PF_CODE, LRS_K_PF_DATA, LRS_K_PF_OWN}) && um[hit ? 6 : 7]);
            8'h26: lane_hit = ((r.kind inside {LRS_K_DATA_DEM, LRS_K_DATA_L1PF}) && um[st])
               || ((r.kind inside {LRS_K_PF_DATA, LRS_K_PF_OWN}) && um[4 + st]);
            8'h27: lane_hit = (r.kind == LRS_K_STORE_OWN && um[st])
               || (r.kind == LRS_K_LOCK_OWN && um[4 + st]);
            8'h28: lane_hit = r.kind == LRS_K_WRITEBACK && um[st] && um[7:4] == 4'h0;
            default: lane_hit = 1'b0;
         endcase
      end
   endfunction

   // configure, then walk every kind and line state on lane 0 back to back, lane 1 busy two cycles in three
   task automatic run_cfg(input logic [7:0] ev, input logic [7:0] um, input logic en);
      lrs_req_t   r0;
      lrs_req_t   r1;
      logic [1:0] ex;
      logic [1:0] pex;
      logic       vld_ex;
      pex = 2'h0;
      vld_ex = um != 8'h00 && ((ev inside {LRS_EV_REQ, LRS_EV_DATA, LRS_EV_WRITE})
         || (ev == LRS_EV_WB && um[7:4] == 4'h0));
      bus_wr(LRS_ADDR_CFG, {15'h0000, en, um, ev});
      bus_rd(LRS_ADDR_CFG, rd_val);
      chk(rd_val, {15'h0000, en, um, ev});
      bus_rd(LRS_ADDR_STAT, rd_val);
      chk({31'h0, rd_val[LRS_STAT_OK]}, {31'h0, vld_ex});
      for (int k = 0; k < 41; k++) begin
         r0 = '{vld: k < 40, kind: lrs_kind_t'(k % 10), line: lrs_line_t'((k / 10) % 4)};
         r1 = '{vld: (k % 3 != 0) && k < 40, kind: lrs_kind_t'((k + 3) % 10), line: lrs_line_t'(k % 4)};
         @(posedge clk);
         cmd <= {r1, r0};
         ex = en ? 2'(lane_hit(ev, um, r0)) + 2'(lane_hit(ev, um, r1)) : 2'h0;
         @(negedge clk);
         if (k == 0) begin
            chk(rdata, 32'h0000_0000);
         end
         chk(32'(cnt_inc), 32'(pex));
         chk(32'(cnt_pulse), 32'(pex != 2'h0));
         pex = ex;
      end
   endtask

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      sel_tab = '{LRS_EV_REQ, LRS_EV_DATA, LRS_EV_WRITE, LRS_EV_WB};
      arst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      cmd = '0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      chk({rdata[29:0], cnt_inc}, 32'h0000_0000);
      arst_n <= 1'b1;
      bus_rd(LRS_ADDR_CFG, rd_val);
      chk(rd_val, 32'(LRS_CFG_RST));
      bus_wr(8'h08, 32'hffff_ffff);
      bus_rd(8'h08, rd_val);
      chk(rd_val, 32'h0000_0000);
      bus_wr(LRS_ADDR_STAT, 32'hffff_ffff);
      bus_rd(LRS_ADDR_STAT, rd_val);
      chk(rd_val, 32'h0000_0000);
      $display("test registers done");
      for (int s = 0; s < 4; s++) begin
         for (int m = 0; m < 256; m++) begin
            run_cfg(sel_tab[s], 8'(m), 1'b1);
         end
         $display("test select %h done", sel_tab[s]);
      end
      run_cfg(8'h25, 8'hff, 1'b1);
      run_cfg(8'h00, 8'hff, 1'b1);
      run_cfg(LRS_EV_REQ, 8'hff, 1'b0);
      $display("test undefined and disabled done");
      stop_test;
   end

   initial begin
      repeat (80000) @(posedge clk);
      n_mismatch++;
      stop_test;
   end
endmodule // lrs_selector_tb_top
`default_nettype wire
